// ==== include/vic_pkg.sv ====
// constants, register map and state type of the vectored interrupt controller
package vic_pkg;

  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [7:0] VIC_OFF_STB    = 8'h00; // serial_timebase_irq_ctrl
  localparam logic [7:0] VIC_OFF_US     = 8'h04; // uart1_spi2_irq_ctrl
  localparam logic [7:0] VIC_OFF_G0     = 8'h08; // timer_match_group0_ctrl
  localparam logic [7:0] VIC_OFF_G1     = 8'h0c; // timer_match_group1_ctrl
  localparam logic [7:0] VIC_OFF_G2     = 8'h10; // eeprom_lowvolt_group_ctrl
  localparam logic [7:0] VIC_OFF_P0     = 8'h14; // pin/conversion/global ctrl
  localparam logic [7:0] VIC_OFF_P1     = 8'h18; // overvoltage/group ctrl
  localparam logic [7:0] VIC_OFF_EDGE   = 8'h1c; // ext_edge_select_reg
  localparam logic [7:0] VIC_OFF_STAT   = 8'h20; // stack and last source

  // ****************************************
  // writable-bit masks and reset values
  // ****************************************
  localparam logic [7:0] VIC_MASK_FULL  = 8'hff;
  localparam logic [7:0] VIC_MASK_PAIR  = 8'h33; // bits 5,4,1,0 only
  localparam logic [7:0] VIC_MASK_P0    = 8'h7f;
  localparam logic [7:0] VIC_MASK_EDGE  = 8'h0f;
  localparam logic [7:0] VIC_RST_REG    = 8'h00;

  // ****************************************
  // field positions
  // ****************************************
  localparam int VIC_P0_GLOBAL  = 0;
  localparam int VIC_FLAG_LSB   = 4; // flags sit four above their enables, three above in p0

  // edge select codes
  localparam logic [1:0] VIC_EDGE_OFF  = 2'h0;
  localparam logic [1:0] VIC_EDGE_RISE = 2'h1;
  localparam logic [1:0] VIC_EDGE_FALL = 2'h2;
  localparam logic [1:0] VIC_EDGE_BOTH = 2'h3;

  // ****************************************
  // sources, priority (index 0 highest), vectors
  // ****************************************
  localparam int VIC_NSRC   = 13;
  localparam int VIC_PCW    = 15;
  localparam int VIC_DEPTH  = 8;
  localparam logic [3:0] VIC_SP_FULL = 4'h8;
  localparam logic [3:0] VIC_SRC_NONE = 4'hf;
  // 0 pin0,1 pin1,2 conv,3 grp0,4 grp1,5 grp2,6 ovp,7 tb_a,8 tb_b,
  // 9 uart_a,10 serial,11 spi2,12 uart_b
  localparam logic [VIC_NSRC-1:0][VIC_PCW-1:0] VIC_VEC_TABLE = {
    15'h0034, 15'h0030, 15'h002c, 15'h0028, 15'h0024, 15'h0020, 15'h001c,
    15'h0018, 15'h0014, 15'h0010, 15'h000c, 15'h0008, 15'h0004};

  // axi response codes
  localparam logic [1:0] VIC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] VIC_RESP_SLVERR = 2'h2;

  // whole state of the controller
  typedef struct packed {
    logic [7:0]                          stb;
    logic [7:0]                          us;
    logic [7:0]                          g0;
    logic [7:0]                          g1;
    logic [7:0]                          g2;
    logic [7:0]                          p0;
    logic [7:0]                          p1;
    logic [7:0]                          edge_sel;
    logic [1:0]                          pin_prev;
    logic [VIC_DEPTH-1:0][VIC_PCW-1:0]   stk;
    logic [3:0]                          sp;
    logic                                aw_got;
    logic                                w_got;
    logic [7:0]                          aw_addr;
    logic [7:0]                          w_byte;
    logic                                w_en;
    logic                                bvalid;
    logic [1:0]                          bresp;
    logic                                rvalid;
    logic [1:0]                          rresp;
    logic [7:0]                          rbyte;
    logic                                vec_valid;
    logic [VIC_PCW-1:0]                  vec_addr;
    logic [3:0]                          last_src;
    logic                                ret_valid;
    logic [VIC_PCW-1:0]                  ret_pc;
    logic                                wake;
  } vic_state_t;

endpackage

// ==== verilog/vic_ctrl.sv ====
// vectored interrupt controller with return stack and axi4-lite registers
`timescale 1ns/1ps
module vic_ctrl
  import vic_pkg::*;
(
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // axi4-lite slave
  input  wire logic [7:0]         awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  input  wire logic [7:0]         araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  // peripheral events, one-cycle pulses
  input  wire logic               ev_serial,
  input  wire logic               ev_uart_a,
  input  wire logic               ev_uart_b,
  input  wire logic               ev_timebase_a,
  input  wire logic               ev_timebase_b,
  input  wire logic               ev_second_spi,
  input  wire logic               ev_conversion,
  input  wire logic               ev_overvoltage,
  input  wire logic [3:0]         ev_group0,
  input  wire logic [3:0]         ev_group1,
  input  wire logic               ev_eeprom,
  input  wire logic               ev_low_voltage,
  // external pins and their sharing setup
  input  wire logic [1:0]         ext_irq_pins,
  input  wire logic [1:0]         pin_func_sel,
  input  wire logic [1:0]         pin_dir_in,
  // core side
  input  wire logic               core_accept,
  input  wire logic [14:0]        core_next_pc,
  input  wire logic               core_call_push,
  input  wire logic               core_ret_pop,
  input  wire logic               return_from_irq_instr,
  output logic                    vec_valid,
  output logic [14:0]             vec_addr,
  output logic                    ret_valid,
  output logic [14:0]             ret_pc,
  output logic                    stack_full,
  output logic                    wake
);

  // ****************************************
  // state
  // ****************************************
  vic_state_t st_r;               // registered state
  vic_state_t st_nxt;             // next state

  // ****************************************
  // combinational helpers
  // ****************************************
  logic                  aw_hs;   // address taken now
  logic                  w_hs;    // data taken now
  logic                  wr_do;   // write completes now
  logic [7:0]            wr_addr; // effective write address
  logic [7:0]            wr_byte; // effective write byte
  logic                  wr_ok;   // byte lane 0 enabled
  logic [1:0]            pin_en;  // pin acting as interrupt input
  logic [1:0]            pin_hit; // selected edge seen
  logic [VIC_NSRC-1:0]   pend;    // enabled pending requests
  logic [VIC_NSRC-1:0]   sel;     // one-hot accepted source
  logic [3:0]            sel_idx; // accepted index
  logic                  take;    // interrupt accepted this cycle
  logic                  pop;     // stack pop this cycle
  logic                  push;    // stack push this cycle
  logic [VIC_PCW-1:0]    push_pc; // value pushed
  logic [3:0]            sp_a;    // pointer after pop
  logic [7:0]            set_stb; // hardware sets per register
  logic [7:0]            set_us;
  logic [7:0]            set_g0;
  logic [7:0]            set_g1;
  logic [7:0]            set_g2;
  logic [7:0]            set_p0;
  logic [7:0]            set_p1;
  logic [7:0]            clr_stb; // service clears per register
  logic [7:0]            clr_us;
  logic [7:0]            clr_p0;
  logic [7:0]            clr_p1;

  // next register value: write, then service clear, then set wins
  function automatic logic [7:0] upd(input logic [7:0] cur,
                                     input logic       hit,
                                     input logic [7:0] dat,
                                     input logic [7:0] mask,
                                     input logic [7:0] clr,
                                     input logic [7:0] set);
    logic [7:0] v;
    v = hit ? dat : cur;
    upd = ((v & mask) & ~clr) | (set & mask);
  endfunction

  // edge detector for one pin
  function automatic logic edge_hit(input logic [1:0] mode,
                                    input logic       prev,
                                    input logic       now);
    case (mode)
      VIC_EDGE_RISE: edge_hit = !prev && now;
      VIC_EDGE_FALL: edge_hit = prev && !now;
      VIC_EDGE_BOTH: edge_hit = prev ^ now;
      default:       edge_hit = 1'b0;
    endcase
  endfunction

  // ****************************************
  // bus handshakes
  // ****************************************
  assign awready = !st_r.aw_got && !st_r.bvalid;
  assign wready  = !st_r.w_got && !st_r.bvalid;
  assign arready = !st_r.rvalid;
  assign aw_hs   = awvalid && awready;
  assign w_hs    = wvalid && wready;
  // write completes once both halves are in, in either order
  assign wr_do   = (st_r.aw_got || aw_hs) && (st_r.w_got || w_hs);
  assign wr_addr = st_r.aw_got ? st_r.aw_addr : awaddr;
  assign wr_byte = st_r.w_got ? st_r.w_byte : wdata[7:0];
  assign wr_ok   = st_r.w_got ? st_r.w_en : wstrb[0];

  // ****************************************
  // request sources
  // ****************************************
  // pin qualification and edge detection
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin_en[i]  = st_r.p0[1+i] && pin_func_sel[i] && pin_dir_in[i];
      pin_hit[i] = pin_en[i] &&
                   edge_hit(st_r.edge_sel[2*i +: 2], st_r.pin_prev[i], ext_irq_pins[i]);
    end
  end

  // hardware sets, aligned with register layouts
  always_comb begin
    set_stb = {ev_serial, ev_uart_a, ev_timebase_b, ev_timebase_a, 4'h0};
    set_us  = {2'h0, ev_uart_b, ev_second_spi, 4'h0};
    set_g0  = {ev_group0, 4'h0};
    set_g1  = {ev_group1, 4'h0};
    set_g2  = {2'h0, ev_eeprom, ev_low_voltage, 4'h0};
    set_p0  = {1'b0, ev_conversion, pin_hit, 4'h0};
    set_p1  = {ev_overvoltage,
               |(set_g2[7:4] & st_r.g2[3:0]),
               |(set_g1[7:4] & st_r.g1[3:0]),
               |(set_g0[7:4] & st_r.g0[3:0]),
               4'h0};
  end

  // ****************************************
  // arbitration
  // ****************************************
  // enabled pending requests
  always_comb begin
    pend[0]  = st_r.p0[4] && st_r.p0[1];
    pend[1]  = st_r.p0[5] && st_r.p0[2];
    pend[2]  = st_r.p0[6] && st_r.p0[3];
    pend[3]  = st_r.p1[4] && st_r.p1[0];
    pend[4]  = st_r.p1[5] && st_r.p1[1];
    pend[5]  = st_r.p1[6] && st_r.p1[2];
    pend[6]  = st_r.p1[7] && st_r.p1[3];
    pend[7]  = st_r.stb[4] && st_r.stb[0];
    pend[8]  = st_r.stb[5] && st_r.stb[1];
    pend[9]  = st_r.stb[6] && st_r.stb[2];
    pend[10] = st_r.stb[7] && st_r.stb[3];
    pend[11] = st_r.us[4] && st_r.us[0];
    pend[12] = st_r.us[5] && st_r.us[1];
  end

  // lowest index wins
  always_comb begin
    sel     = '0;
    sel_idx = VIC_SRC_NONE;
    for (int i = VIC_NSRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        sel     = '0;
        sel[i]  = 1'b1;
        sel_idx = 4'(i);
      end
    end
  end

  // acceptance; a pop the same cycle defers the take by one cycle
  // global enable and stack room
  assign take = core_accept && st_r.p0[VIC_P0_GLOBAL] && (|pend) &&
                (st_r.sp != VIC_SP_FULL) && !pop;
  assign stack_full = (st_r.sp == VIC_SP_FULL);

  // service clears; group sources keep their own flags
  always_comb begin
    clr_p0  = '0;
    clr_p1  = '0;
    clr_stb = '0;
    clr_us  = '0;
    if (take) begin
      clr_p0[VIC_P0_GLOBAL] = 1'b1;
    end
    clr_p0[6:4] = sel[2:0] & {3{take}};
    clr_p1[7:4] = {sel[6], sel[5:3]} & {4{take}};
    clr_stb[7:4] = {sel[10], sel[9], sel[8], sel[7]} & {4{take}};
    clr_us[5:4]  = {sel[12], sel[11]} & {2{take}};
  end

  // ****************************************
  // return stack
  // ****************************************
  // pop on return
  assign pop     = (return_from_irq_instr || core_ret_pop) && (st_r.sp != 4'h0);
  assign push    = take || core_call_push;
  assign push_pc = core_next_pc;
  assign sp_a    = pop ? (st_r.sp - 4'h1) : st_r.sp;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    // pin history always follows the pins
    st_nxt.pin_prev = ext_irq_pins;

    // registers with software write and hardware set, service clear on stb, us, p0, p1 only; edge_sel takes writes only
    // writable flags and enables
    st_nxt.stb = upd(st_r.stb, wr_do && wr_ok && wr_addr == VIC_OFF_STB,
                     wr_byte, VIC_MASK_FULL, clr_stb, set_stb);
    st_nxt.us  = upd(st_r.us, wr_do && wr_ok && wr_addr == VIC_OFF_US,
                     wr_byte, VIC_MASK_PAIR, clr_us, set_us);
    st_nxt.g0  = upd(st_r.g0, wr_do && wr_ok && wr_addr == VIC_OFF_G0,
                     wr_byte, VIC_MASK_FULL, 8'h00, set_g0);
    st_nxt.g1  = upd(st_r.g1, wr_do && wr_ok && wr_addr == VIC_OFF_G1,
                     wr_byte, VIC_MASK_FULL, 8'h00, set_g1);
    st_nxt.g2  = upd(st_r.g2, wr_do && wr_ok && wr_addr == VIC_OFF_G2,
                     wr_byte, VIC_MASK_PAIR, 8'h00, set_g2);
    st_nxt.p0  = upd(st_r.p0, wr_do && wr_ok && wr_addr == VIC_OFF_P0,
                     wr_byte, VIC_MASK_P0, clr_p0, set_p0);
    st_nxt.p1  = upd(st_r.p1, wr_do && wr_ok && wr_addr == VIC_OFF_P1,
                     wr_byte, VIC_MASK_FULL, clr_p1, set_p1);
    st_nxt.edge_sel = upd(st_r.edge_sel, wr_do && wr_ok && wr_addr == VIC_OFF_EDGE,
                          wr_byte, VIC_MASK_EDGE, 8'h00, 8'h00);

    // write channel capture
    if (aw_hs) begin
      st_nxt.aw_got  = 1'b1;
      st_nxt.aw_addr = awaddr;
    end
    if (w_hs) begin
      st_nxt.w_got  = 1'b1;
      st_nxt.w_byte = wdata[7:0];
      st_nxt.w_en   = wstrb[0];
    end
    // response once both halves arrived
    if (wr_do) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = (wr_addr <= VIC_OFF_EDGE && wr_addr[1:0] == 2'h0) ?
                      VIC_RESP_OKAY : VIC_RESP_SLVERR;
    end else if (st_r.bvalid && bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // read channel: data latched at the address handshake
    if (arvalid && arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = VIC_RESP_OKAY;
      case (araddr)
        VIC_OFF_STB:  st_nxt.rbyte = st_r.stb;
        VIC_OFF_US:   st_nxt.rbyte = st_r.us;
        VIC_OFF_G0:   st_nxt.rbyte = st_r.g0;
        VIC_OFF_G1:   st_nxt.rbyte = st_r.g1;
        VIC_OFF_G2:   st_nxt.rbyte = st_r.g2;
        VIC_OFF_P0:   st_nxt.rbyte = st_r.p0;
        VIC_OFF_P1:   st_nxt.rbyte = st_r.p1;
        VIC_OFF_EDGE: st_nxt.rbyte = st_r.edge_sel;
        VIC_OFF_STAT: st_nxt.rbyte = {st_r.sp, st_r.last_src};
        default: begin
          // unmapped: zero data, slave error
          st_nxt.rbyte = 8'h00;
          st_nxt.rresp = VIC_RESP_SLVERR;
        end
      endcase
    end else if (st_r.rvalid && rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // stack pop then push
    st_nxt.ret_valid = pop;
    if (pop) begin
      st_nxt.ret_pc = st_r.stk[sp_a[2:0]];
    end
    st_nxt.sp = sp_a;
    // a call on a full stack is dropped; the core owns that overflow
    if (push && sp_a != VIC_SP_FULL) begin
      st_nxt.stk[sp_a[2:0]] = push_pc;
      st_nxt.sp             = sp_a + 4'h1;
    end

    // vector output
    st_nxt.vec_valid = take;
    if (take) begin
      st_nxt.vec_addr = VIC_VEC_TABLE[sel_idx];
      st_nxt.last_src = sel_idx;
    end

    // wake on any flag being set by hardware, whether or not it was already set
    // wake pulse
    st_nxt.wake = |{set_stb, set_us, set_g0, set_g1, set_g2, set_p0, set_p1};
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r          <= '0;
      st_r.stb      <= VIC_RST_REG;
      st_r.last_src <= VIC_SRC_NONE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // outputs from flip-flops
  // ****************************************
  assign bvalid    = st_r.bvalid;
  assign bresp     = st_r.bresp;
  assign rvalid    = st_r.rvalid;
  assign rresp     = st_r.rresp;
  assign rdata     = {24'h000000, st_r.rbyte};
  assign vec_valid = st_r.vec_valid;
  assign vec_addr  = st_r.vec_addr;
  assign ret_valid = st_r.ret_valid;
  assign ret_pc    = st_r.ret_pc;
  assign wake      = st_r.wake;

endmodule

// ==== dv/vic_ctrl_asserts.sv ====
// concurrent checks on the ports of the vectored interrupt controller
`timescale 1ns/1ps
module vic_ctrl_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        ev_serial,
  input wire logic        ev_uart_a,
  input wire logic        ev_timebase_a,
  input wire logic        core_accept,
  input wire logic        core_call_push,
  input wire logic        core_ret_pop,
  input wire logic        return_from_irq_instr,
  input wire logic        vec_valid,
  input wire logic [14:0] vec_addr,
  input wire logic        ret_valid,
  input wire logic        stack_full,
  input wire logic        wake
);
  // ****************************************
  // one clock domain, reset disables all
  // ****************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_vec_single: assert property (vec_valid |=> !vec_valid)
    else $error("vector pulse longer than one cycle");
  a_take_cause: assert property (vec_valid |-> $past(core_accept) && !$past(stack_full))
    else $error("take without core accept or with full stack");
  a_vec_range: assert property (vec_valid |-> vec_addr[1:0] == 2'h0
    && vec_addr >= 15'h0004 && vec_addr <= 15'h0034) else $error("vector outside table");
  a_vec_hold: assert property (!vec_valid |-> $stable(vec_addr))
    else $error("vector moved without a take");
  a_ret_cause: assert property (ret_valid |-> $past(return_from_irq_instr || core_ret_pop))
    else $error("pop answer without a pop");
  a_full_cause: assert property ($rose(stack_full) |-> vec_valid || $past(core_call_push))
    else $error("stack filled without a push");
  a_wake_event: assert property ((ev_serial || ev_uart_a || ev_timebase_a) |=> wake)
    else $error("flag event without wake pulse");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  a_rdata_upper: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("reserved read bits not zero");
  c_take: cover property (vec_valid);
  c_full: cover property (stack_full);
  c_ret:  cover property (ret_valid);
endmodule

bind vic_ctrl vic_ctrl_asserts i_chk (.aclk(aclk), .aresetn(aresetn), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
  .ev_serial(ev_serial), .ev_uart_a(ev_uart_a), .ev_timebase_a(ev_timebase_a),
  .core_accept(core_accept), .core_call_push(core_call_push), .core_ret_pop(core_ret_pop),
  .return_from_irq_instr(return_from_irq_instr), .vec_valid(vec_valid),
  .vec_addr(vec_addr), .ret_valid(ret_valid), .stack_full(stack_full), .wake(wake));

// ==== dv/vic_core_model.sv ====
// core model: offers the pc, records the pushed pc, returns from service
`timescale 1ns/1ps
module vic_core_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        acc_en,
  input  wire logic        auto_ret,
  input  wire logic        vec_valid,
  output logic             core_accept,
  output logic [14:0]      core_next_pc,
  output logic             return_from_irq_instr,
  output logic [14:0]      saved_pc
);
  logic [14:0] prev_r; // pc offered at the previous edge, the one a take pushes
  logic [2:0]  cnt_r;  // short service routine
  assign core_accept = acc_en;
  // pc moves every cycle so a wrong push slot shows up
  always @(posedge aclk) begin
    if (!aresetn) begin
      core_next_pc <= 15'h0100;
      prev_r <= 15'h0000;
      cnt_r <= 3'h0;
      return_from_irq_instr <= 1'b0;
      saved_pc <= 15'h0000;
    end else begin
      core_next_pc <= core_next_pc + 15'h0001;
      prev_r <= core_next_pc;
      return_from_irq_instr <= (cnt_r == 3'h1);
      cnt_r <= (cnt_r != 3'h0) ? cnt_r - 3'h1 : 3'h0;
      if (vec_valid) begin
        saved_pc <= prev_r;
        if (auto_ret) cnt_r <= 3'h4;
      end
    end
  end
endmodule

// ==== dv/tb_top.sv ====
// self-checking testbench of the vectored interrupt controller
`timescale 1ns/1ps
module tb_top;
  import vic_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, push, pop;
  logic        acc_en, auto_ret, awready, wready, bvalid, arready, rvalid, core_accept;
  logic        rfi, vec_valid, ret_valid, stack_full, wake;
  logic [7:0]  awaddr, araddr, q8;
  logic [31:0] wdata, rdata, q;
  logic [9:0]  evs;
  logic [3:0]  evg0, evg1, strb;
  logic [1:0]  pins, fsel, dirin, bresp, rresp, r, code;
  logic [14:0] next_pc, vec_addr, ret_pc, saved_pc;
  logic [12:0] pend;
  int          fail_count, tests_run, vcnt, i, k, n0;
  localparam logic [7:0] MASK [8] = '{VIC_MASK_FULL, VIC_MASK_PAIR, VIC_MASK_FULL,
    VIC_MASK_FULL, VIC_MASK_PAIR, VIC_MASK_P0, VIC_MASK_FULL, VIC_MASK_EDGE};

  always #20 aclk = ~aclk;
  always @(posedge aclk) if (vec_valid === 1'b1) vcnt++; // count takes

  vic_ctrl i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(strb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .ev_serial(evs[0]), .ev_uart_a(evs[1]), .ev_uart_b(evs[2]), .ev_timebase_a(evs[3]),
    .ev_timebase_b(evs[4]), .ev_second_spi(evs[5]), .ev_conversion(evs[6]),
    .ev_overvoltage(evs[7]), .ev_group0(evg0), .ev_group1(evg1), .ev_eeprom(evs[8]),
    .ev_low_voltage(evs[9]), .ext_irq_pins(pins), .pin_func_sel(fsel), .pin_dir_in(dirin),
    .core_accept(core_accept), .core_next_pc(next_pc), .core_call_push(push),
    .core_ret_pop(pop), .return_from_irq_instr(rfi), .vec_valid(vec_valid),
    .vec_addr(vec_addr), .ret_valid(ret_valid), .ret_pc(ret_pc), .stack_full(stack_full),
    .wake(wake));
  vic_core_model i_core (.aclk(aclk), .aresetn(aresetn), .acc_en(acc_en),
    .auto_ret(auto_ret), .vec_valid(vec_valid), .core_accept(core_accept),
    .core_next_pc(next_pc), .return_from_irq_instr(rfi), .saved_pc(saved_pc));

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one axi4-lite transfer; bready and rready stay high
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    logic ap, wp, dn;
    ap = 1'b1; wp = w; dn = 1'b0; n = 0;
    if (w) begin awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1; end
    else begin araddr <= a; arvalid <= 1'b1; end
    while (!dn && n < 100) begin
      @(posedge aclk);
      n++;
      if (!w && rvalid) begin dn = 1'b1; q = rdata; r = rresp; end
      if (w && !ap && !wp && bvalid) begin dn = 1'b1; r = bresp; end
      if (ap && w && awready) begin ap = 1'b0; awvalid <= 1'b0; end
      if (ap && !w && arready) begin ap = 1'b0; arvalid <= 1'b0; end
      if (wp && wready) begin wp = 1'b0; wvalid <= 1'b0; end
    end
    if (!dn) begin fail_count++; end_of_test(); end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    bus(1'b1, a, d);
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    bus(1'b0, a, 8'h00);
    chk(q, {24'h0, e});
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic wsig(input logic which); // take 0, pop 1
    int n;
    n = 0;
    do begin @(posedge aclk); n++; end while (!(which ? ret_valid : vec_valid) && n < 200);
    if (n >= 200) begin fail_count++; end_of_test(); end
  endtask
  function automatic int first_set(input logic [12:0] p);
    for (int j = 12; j >= 0; j--) if (p[j]) first_set = j;
  endfunction

  initial begin repeat (60000) @(posedge aclk); fail_count++; end_of_test(); end
  initial begin
    aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; arvalid = 0; bready = 1; rready = 1;
    awaddr = 0; araddr = 0; wdata = 0; evs = 0; evg0 = 0; evg1 = 0; pins = 0; fsel = 3;
    dirin = 3; push = 0; pop = 0; acc_en = 0; auto_ret = 1; fail_count = 0; tests_run = 0;
    vcnt = 0; strb = 4'hf;
    void'($urandom(32'h7f59));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 8; i++) rdc(8'(4 * i), 8'h00, VIC_RESP_OKAY);
    rdc(VIC_OFF_STAT, 8'h0f, VIC_RESP_OKAY);
    rdc(8'h24, 8'h00, VIC_RESP_SLVERR);
    wr(VIC_OFF_STAT, 8'hff, VIC_RESP_SLVERR);
    wr(8'h02, 8'hff, VIC_RESP_SLVERR);
    for (k = 0; k < 24; k++) begin
      q8 = 8'($urandom);
      wr(8'(4 * (k % 8)), q8, VIC_RESP_OKAY);
      rdc(8'(4 * (k % 8)), q8 & MASK[k % 8], VIC_RESP_OKAY);
    end
    for (i = 0; i < 8; i++) wr(8'(4 * i), 8'h00, VIC_RESP_OKAY);
    strb <= 4'he;
    wr(VIC_OFF_G0, 8'h0f, VIC_RESP_OKAY);
    // random events with every enable low, held until read back
    evs <= 10'($urandom); evg0 <= 4'($urandom); evg1 <= 4'($urandom); strb <= 4'hf;
    @(posedge aclk);
    rdc(VIC_OFF_STB, {evs[0], evs[1], evs[4], evs[3], 4'h0}, VIC_RESP_OKAY);
    rdc(VIC_OFF_US, {2'h0, evs[2], evs[5], 4'h0}, VIC_RESP_OKAY);
    rdc(VIC_OFF_G0, {evg0, 4'h0}, VIC_RESP_OKAY);
    rdc(VIC_OFF_G1, {evg1, 4'h0}, VIC_RESP_OKAY);
    rdc(VIC_OFF_G2, {2'h0, evs[8], evs[9], 4'h0}, VIC_RESP_OKAY);
    rdc(VIC_OFF_P0, {1'b0, evs[6], 6'h0}, VIC_RESP_OKAY);
    rdc(VIC_OFF_P1, {evs[7], 7'h0}, VIC_RESP_OKAY);
    evs <= 0; evg0 <= 0; evg1 <= 0;
    acc_en <= 1'b1;
    wr(VIC_OFF_P0, 8'h01, VIC_RESP_OKAY);
    repeat (6) @(posedge aclk);
    chk(vcnt, 0);
    wr(VIC_OFF_P0, 8'h7e, VIC_RESP_OKAY);
    wr(VIC_OFF_STB, 8'hff, VIC_RESP_OKAY);
    wr(VIC_OFF_US, 8'h33, VIC_RESP_OKAY);
    wr(VIC_OFF_G0, 8'hff, VIC_RESP_OKAY);
    wr(VIC_OFF_P1, 8'hff, VIC_RESP_OKAY);
    chk(vcnt, 0);
    // every source pending: serve them one by one, highest first
    pend = 13'h1fff;
    for (k = 0; k < 13; k++) begin
      rdc(VIC_OFF_P0, {1'b0, pend[2:0] & 3'h7, 4'he}, VIC_RESP_OKAY);
      wr(VIC_OFF_P0, q[7:0] | 8'h01, VIC_RESP_OKAY);
      wsig(1'b0);
      chk(vec_addr, 15'(4 * (first_set(pend) + 1)));
      pend[first_set(pend)] = 1'b0;
      wsig(1'b1);
      chk(ret_pc, saved_pc);
    end
    rdc(VIC_OFF_G0, 8'hff, VIC_RESP_OKAY);
    rdc(VIC_OFF_P1, 8'h0f, VIC_RESP_OKAY);
    // edge codes per pin qualification, both transitions
    acc_en <= 1'b0;
    for (i = 0; i < 6; i++) begin
      code = (i < 4) ? 2'(i) : VIC_EDGE_BOTH;
      fsel <= {1'b1, i != 4};
      dirin <= {1'b1, i != 5};
      wr(VIC_OFF_EDGE, {6'h0, code}, VIC_RESP_OKAY);
      wr(VIC_OFF_P0, 8'h02, VIC_RESP_OKAY);
      pins <= 2'h3;
      repeat (2) @(posedge aclk);
      rdc(VIC_OFF_P0, {3'h0, code[0] && i < 4, 4'h2}, VIC_RESP_OKAY);
      wr(VIC_OFF_P0, 8'h02, VIC_RESP_OKAY);
      pins <= 2'h0;
      repeat (2) @(posedge aclk);
      rdc(VIC_OFF_P0, {3'h0, code[1] && i < 4, 4'h2}, VIC_RESP_OKAY);
    end
    // full stack holds a pending request back until one pop
    acc_en <= 1'b1;
    auto_ret <= 1'b0;
    push <= 1'b1;
    repeat (8) @(posedge aclk);
    push <= 1'b0;
    @(posedge aclk);
    chk({31'h0, stack_full}, 32'h1);
    n0 = vcnt;
    wr(VIC_OFF_STB, 8'h11, VIC_RESP_OKAY);
    wr(VIC_OFF_P0, 8'h01, VIC_RESP_OKAY);
    repeat (6) @(posedge aclk);
    chk(vcnt, n0);
    pop <= 1'b1;
    @(posedge aclk);
    pop <= 1'b0;
    wsig(1'b0);
    chk(vec_addr, 15'h0020);
    end_of_test();
  end
endmodule
